// File: inc/pap_defines.svh
// constants for the dual mode parallel / aux port
// assumes a 25 MHz core clock; included by both ends
`ifndef PAP_DEFINES_SVH
`define PAP_DEFINES_SVH
`define PAP_CORE_HZ 25000000
// pin slots of the link vector
`define PAP_NPIN 10
`define PAP_P_STB 0
`define PAP_P_BUSY 1
`define PAP_P_FAULT 2
`define PAP_P_INIT 3
`define PAP_P_PERR 4
`define PAP_P_SEL 5
`define PAP_P_SELIN 6
`define PAP_P_AUTOFD 7
`define PAP_P_ACK 8
`define PAP_P_DIR 9
// idle levels of the board: pull-ups, direction pin pulled down
`define PAP_PULL 10'h1ff
// device drive masks per mode
`define PAP_DOE_1284 10'h336
`define PAP_DOE_AOUT 10'h3fe
`define PAP_DOE_AIN 10'h200
// host drive masks per mode
`define PAP_HOE_1284 10'h0c9
`define PAP_HOE_ASRC 10'h0c7
`define PAP_HOE_ASNK 10'h001
// register byte offsets
`define PAP_A_SYS 8'h00
`define PAP_A_GP 8'h04
`define PAP_A_AC 8'h08
`define PAP_A_ST 8'h0c
// field positions
`define PAP_SYS_AUX 4
`define PAP_GP_GPIO 3
`define PAP_AC_PIN 4
`define PAP_AC_DIR 0
`define PAP_AC_CLK 1
// timing: acknowledge width and host strobe width
`define PAP_ACK_NS 500
`define PAP_STB_NS 500
`define PAP_CYC(ns) (((ns) * (`PAP_CORE_HZ / 1000000) + 999) / 1000)
`define PAP_ACK_CYC `PAP_CYC(`PAP_ACK_NS)
`define PAP_STB_CYC `PAP_CYC(`PAP_STB_NS)
// aux clock rates and phase steps (two steps per clock period)
`define PAP_F0_HZ 64'd13500000
`define PAP_F1_HZ 64'd6750000
`define PAP_F2_HZ 64'd3375000
`define PAP_STEP(f) ((f) * 64'd131072 / `PAP_CORE_HZ)
`define PAP_HALF_DEF 4
`endif

// File: inc/pap_link_if.sv
// shared pins between the port device and its host
// resolves each wire from the two drivers and the board pulls
`timescale 1ns/1ps
`include "pap_defines.svh"
interface pap_link_if;
  logic [`PAP_NPIN-1:0] dev_o, dev_oe, host_o, host_oe, pin; // control pins
  logic [7:0] dev_d, host_d, data; // parallel data bus
  logic dev_doe, host_doe; // data bus enables
  localparam logic [`PAP_NPIN-1:0] PULL = `PAP_PULL; // board idle level per pin
  genvar i;
  // wire level per pin, pull when nobody drives
  generate
    for (i = 0; i < `PAP_NPIN; i++)
    begin : g_pin
      assign pin[i] = dev_oe[i] ? dev_o[i] : host_oe[i] ? host_o[i] : PULL[i];
    end
  endgenerate
  assign data = dev_doe ? dev_d : host_doe ? host_d : 8'hff;
  modport dev (input pin, data, output dev_o, dev_oe, dev_d, dev_doe);
  modport host (input pin, data, output host_o, host_oe, host_d, host_doe);
endinterface

// File: inc/pap_pkg.sv
// types shared by both ends of the parallel / aux port
// assumes the defines header for field widths
package pap_pkg;
  // device port sequencer
  typedef enum logic [1:0] {PAP_IDLE, PAP_STORE, PAP_ACK} pap_dst_t;
  // host 1284 sender
  typedef enum logic [2:0] {PAP_H_IDLE, PAP_H_SETUP, PAP_H_STB, PAP_H_WAIT, PAP_H_DONE} pap_hst_t;
  // all device state
  typedef struct packed {
    logic [17:0] s1, s2, s3;
    logic rel, strap, aux_sel, gpio, pin_direction_control, dir_out;
    logic [1:0] clk_sel;
    logic a_act, a_wr;
    logic [7:0] a_addr;
    pap_dst_t st;
    logic [7:0] cnt;
    logic overrun, perr, selected;
    logic [17:0] acc;
    logic aclk, tsync, tadp, tnm, tval;
    logic [2:0] ttag;
    logic [7:0] tdata;
    logic [7:0] rdata;
    logic rsync, rerr, rvalid;
  } pap_dev_t;
  // all host state
  typedef struct packed {
    logic [17:0] s1, s2, s3;
    pap_hst_t st;
    logic [7:0] cnt, dcnt;
    logic [7:0] d;
    logic stb_n, hclk, hval, hsync, herr;
    logic [7:0] sdata;
    logic [2:0] stag;
    logic ssync, sadp, snm, svalid;
  } pap_host_t;
endpackage

// File: rtl/pap_device.sv
// device end of the dual mode parallel / aux port, with AHB-Lite registers
// assumes link pins are asynchronous to core_clk; host keeps its own rules
//
// Contract
// RULE1 - busy high whenever port cannot take data
// RULE2 - sync marker flags first packet byte
// RULE3 - fault asserted on overrun errors
// RULE4 - device makes aux clock at chosen rate; the 13.5 MHz select saturates at 12.5 MHz, half the core rate
// RULE5 - source supplies aux clock in input mode
// RULE6 - init low resets 1284 logic to idle
// RULE7 - three bit packet tag beside output bytes
// RULE8 - eight bit bus carries both byte kinds
// RULE9 - direction output steers buffers, high in aux
// RULE10 - strap sampled on direction pin at reset
// RULE11 - paper error on processing error, with fault
// RULE12 - select high when port is selected
// RULE13 - host pulls select-in low to select
// RULE14 - adaptation flag for adaptation field bytes
// RULE15 - source flags bytes of errored packets
// RULE16 - byte captured on strobe rising edge
// RULE17 - external pin sets aux direction when enabled
// RULE18 - gpio mode bit releases all port pins
// RULE19 - aux select bit picks aux over 1284
// RULE20 - data valid only while byte valid
// RULE21 - no-match flag for filtered-out packets
// RULE22 - busy until stored, then ack, then release
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pap_defines.svh"
module pap_device
(
  input wire logic core_clk,
  input wire logic sys_rst,
  pap_link_if.dev link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic proc_error,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_sync,
  input wire logic [2:0] tx_tag,
  input wire logic tx_adapt,
  input wire logic tx_nomatch,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_sync,
  output logic rx_err
);
  import pap_pkg::*;

  pap_dev_t r; // registered state
  pap_dev_t n; // next state
  logic aux_out; // aux port sends
  logic [17:0] acc_sum; // phase accumulator sum
  logic tick; // half period of the aux clock elapsed
  logic [9:0] vec_1284; // pin values in 1284 mode
  logic [9:0] vec_aux; // pin values in aux mode
  logic [9:0] p; // synchronised pins
  logic [9:0] q; // pins one cycle older
  logic [7:0] pd; // synchronised data bus

  // phase step per clock select; 13.5 MHz saturates at half core rate
  function automatic logic [17:0] step_of(input logic [1:0] sel);
    case (sel)
      2'h0: step_of = 18'(`PAP_STEP(`PAP_F0_HZ));
      2'h1: step_of = 18'(`PAP_STEP(`PAP_F1_HZ));
      default: step_of = 18'(`PAP_STEP(`PAP_F2_HZ));
    endcase
  endfunction

  // register read mux, unmapped offsets read zero
  function automatic logic [31:0] rd(input pap_dev_t s);
    rd = 32'h0;
    case (s.a_addr)
      `PAP_A_SYS: rd[`PAP_SYS_AUX] = s.aux_sel;
      `PAP_A_GP: rd[`PAP_GP_GPIO] = s.gpio;
      `PAP_A_AC: rd[4:0] = {s.pin_direction_control, 1'b0, s.clk_sel, s.dir_out};
      `PAP_A_ST: rd[5:0] = {s.selected, aux_out, s.st != PAP_IDLE, s.strap, s.perr, s.overrun};
      default: rd = 32'h0;
    endcase
  endfunction

  assign p = r.s2[9:0];
  assign q = r.s3[9:0];
  assign pd = r.s2[17:10];
  // aux direction from external pin or from software
  assign aux_out = !r.gpio && r.aux_sel && (r.pin_direction_control ? p[`PAP_P_STB] : r.dir_out); // RULE17
  assign acc_sum = r.acc + step_of(r.clk_sel);
  assign tick = aux_out && (acc_sum >= 18'h10000); // RULE4

  // one combinational step of the whole port
  always_comb
  begin
    n = r;
    n.s1 = {link.data, link.pin};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.rvalid = 1'b0;
    n.rel = 1'b1;
    // ahb data phase write; clears first so hardware sets win
    if (r.a_act && r.a_wr)
    begin
      case (r.a_addr)
        `PAP_A_SYS: n.aux_sel = hwdata[`PAP_SYS_AUX]; // RULE19
        `PAP_A_GP: n.gpio = hwdata[`PAP_GP_GPIO]; // RULE18
        `PAP_A_AC:
        begin
          n.pin_direction_control = hwdata[`PAP_AC_PIN];
          n.dir_out = hwdata[`PAP_AC_DIR];
          n.clk_sel = hwdata[`PAP_AC_CLK+1:`PAP_AC_CLK];
        end
        `PAP_A_ST:
        begin
          // write one to clear the error flags
          if (hwdata[0])
            n.overrun = 1'b0;
          if (hwdata[1])
            n.perr = 1'b0;
        end
        default: n.aux_sel = r.aux_sel;
      endcase
    end
    // ahb address phase capture
    n.a_act = hsel && htrans[1] && hready;
    n.a_addr = haddr[7:0];
    n.a_wr = hwrite;
    if (!r.gpio && !r.aux_sel)
    begin
      // 1284 peripheral
      if (!p[`PAP_P_SELIN])
        n.selected = 1'b1; // RULE12
      if (proc_error)
        n.perr = 1'b1; // RULE11
      case (r.st)
        PAP_IDLE:
        begin
          // capture on strobe rise
          if (p[`PAP_P_STB] && !q[`PAP_P_STB])
          begin
            n.rdata = pd; // RULE16 RULE8
            n.st = PAP_STORE;
          end
        end
        PAP_STORE:
        begin
          // hand the byte to the user side, then acknowledge
          n.rvalid = 1'b1; // RULE22
          n.rsync = 1'b0;
          n.rerr = 1'b0;
          n.cnt = 8'(`PAP_ACK_CYC - 1);
          n.st = PAP_ACK;
        end
        PAP_ACK:
        begin
          // ack low for its width, busy released with it
          if (r.cnt == 8'h0)
            n.st = PAP_IDLE; // RULE22
          else
            n.cnt = r.cnt - 8'h1;
        end
        default: n.st = PAP_IDLE;
      endcase
      // a new strobe while still busy is an overrun
      if (r.st != PAP_IDLE && !p[`PAP_P_STB] && q[`PAP_P_STB])
        n.overrun = 1'b1; // RULE3
      // init low returns the port to idle
      if (!p[`PAP_P_INIT])
      begin
        n.st = PAP_IDLE; // RULE6
        n.cnt = 8'h0;
        n.overrun = 1'b0;
        n.perr = 1'b0;
        n.selected = 1'b0;
      end
    end
    else
      n.st = PAP_IDLE;
    // aux output: new byte after each falling aux clock
    if (aux_out)
    begin
      n.acc = tick ? acc_sum - 18'h10000 : acc_sum;
      if (tick)
      begin
        n.aclk = !r.aclk; // RULE4
        if (r.aclk)
        begin
          n.tval = tx_valid; // RULE20
          if (tx_valid)
          begin
            n.tdata = tx_data; // RULE8
            n.tsync = tx_sync; // RULE2
            n.ttag = tx_tag; // RULE7
            n.tadp = tx_adapt; // RULE14
            n.tnm = tx_nomatch; // RULE21
          end
        end
      end
    end
    else
    begin
      n.acc = 18'h0;
      n.aclk = 1'b0;
      n.tval = 1'b0;
    end
    // aux input: sample on rising aux clock from the source
    if (!r.gpio && r.aux_sel && !aux_out && p[`PAP_P_FAULT] && !q[`PAP_P_FAULT]) // RULE5
    begin
      n.rdata = pd; // RULE8
      n.rsync = p[`PAP_P_BUSY]; // RULE2
      n.rerr = p[`PAP_P_SELIN]; // RULE15
      n.rvalid = p[`PAP_P_AUTOFD]; // RULE20
    end
    // synchronous reset; strap taken from the settled pin
    if (sys_rst)
    begin
      n = '0;
      n.s1 = {link.data, link.pin};
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.strap = r.s2[`PAP_P_DIR]; // RULE10
      n.st = PAP_IDLE; // RULE1
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    r <= n;
  end

  // pin values; ack and fault active low in 1284 mode
  assign vec_1284 = {1'b0, r.st != PAP_ACK, 2'b11, r.selected, r.perr, 1'b1,
                     !(r.overrun || r.perr), r.st != PAP_IDLE, 1'b1}; // RULE1 RULE3 RULE11 RULE9
  assign vec_aux = {1'b1, r.tnm, r.tval, r.tadp, r.ttag[1], r.ttag[0], r.ttag[2],
                    r.aclk, r.tsync, 1'b0}; // RULE9 RULE7
  assign link.dev_o = r.aux_sel ? vec_aux : vec_1284;
  // gpio mode releases everything; strap pin free during reset
  assign link.dev_oe = (r.gpio || !r.rel) ? 10'h0 :
                       !r.aux_sel ? `PAP_DOE_1284 : aux_out ? `PAP_DOE_AOUT : `PAP_DOE_AIN; // RULE18 RULE10
  assign link.dev_d = r.tdata;
  assign link.dev_doe = aux_out && r.rel;
  // ahb answers in zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = (r.a_act && !r.a_wr) ? rd(r) : 32'h0;
  // user side
  assign tx_ready = tick && r.aclk;
  assign rx_valid = r.rvalid;
  assign rx_data = r.rdata;
  assign rx_sync = r.rsync;
  assign rx_err = r.rerr;
endmodule

// File: rtl/pap_host.sv
// host end: 1284 byte sender, aux stream source and aux stream sink
// assumes device pins asynchronous to core_clk
`timescale 1ns/1ps
`include "pap_defines.svh"
module pap_host
#(
  parameter int HALF = `PAP_HALF_DEF
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  pap_link_if.host link,
  input wire logic aux_mode,
  input wire logic aux_dev_out,
  input wire logic strap_value,
  input wire logic init_req,
  input wire logic sel_req,
  input wire logic send_valid,
  input wire logic [7:0] send_data,
  output logic send_ready,
  output logic dev_busy,
  output logic dev_fault,
  output logic dev_perror,
  output logic dev_select,
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  input wire logic src_sync,
  input wire logic src_err,
  output logic src_ready,
  output logic snk_valid,
  output logic [7:0] snk_data,
  output logic snk_sync,
  output logic [2:0] snk_tag,
  output logic snk_adp,
  output logic snk_nm
);
  import pap_pkg::*;

  pap_host_t r; // registered state
  pap_host_t n; // next state
  logic [9:0] p; // synchronised pins
  logic [9:0] q; // older pins
  logic src_on; // host sources the aux stream
  logic fall; // host aux clock about to fall
  logic [9:0] vec; // pin values

  assign p = r.s2[9:0];
  assign q = r.s3[9:0];
  assign src_on = aux_mode && !aux_dev_out;
  assign fall = src_on && r.hclk && r.dcnt == 8'h0;

  // one combinational step of the host
  always_comb
  begin
    n = r;
    n.s1 = {link.data, link.pin};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.svalid = 1'b0;
    // 1284 sender: setup, strobe low, release, wait for ack
    case (r.st)
      PAP_H_IDLE:
      begin
        if (send_valid && send_ready)
        begin
          n.d = send_data;
          n.cnt = 8'(`PAP_STB_CYC - 1);
          n.st = PAP_H_SETUP;
        end
      end
      PAP_H_SETUP:
      begin
        if (r.cnt == 8'h0)
        begin
          n.stb_n = 1'b0; // RULE16
          n.cnt = 8'(`PAP_STB_CYC - 1);
          n.st = PAP_H_STB;
        end
        else
          n.cnt = r.cnt - 8'h1;
      end
      PAP_H_STB:
      begin
        if (r.cnt == 8'h0)
        begin
          n.stb_n = 1'b1; // RULE16
          n.st = PAP_H_WAIT;
        end
        else
          n.cnt = r.cnt - 8'h1;
      end
      PAP_H_WAIT:
      begin
        if (!p[`PAP_P_ACK])
          n.st = PAP_H_DONE;
      end
      PAP_H_DONE:
      begin
        if (p[`PAP_P_ACK] && !p[`PAP_P_BUSY])
          n.st = PAP_H_IDLE;
      end
      default: n.st = PAP_H_IDLE;
    endcase
    if (aux_mode || init_req)
    begin
      n.st = PAP_H_IDLE;
      n.stb_n = 1'b1;
    end
    // aux source clock from a divider, bytes change on the fall
    if (src_on)
    begin
      if (r.dcnt == 8'h0)
      begin
        n.dcnt = 8'(HALF - 1);
        n.hclk = !r.hclk; // RULE5
        if (r.hclk)
        begin
          n.hval = src_valid; // RULE20
          if (src_valid)
          begin
            n.d = src_data;
            n.hsync = src_sync; // RULE2
            n.herr = src_err; // RULE15
          end
        end
      end
      else
        n.dcnt = r.dcnt - 8'h1;
    end
    else
    begin
      n.hclk = 1'b0;
      n.hval = 1'b0;
      n.dcnt = 8'h0;
    end
    // aux sink: sample device bytes on rising aux clock
    if (aux_mode && aux_dev_out && p[`PAP_P_FAULT] && !q[`PAP_P_FAULT] && p[`PAP_P_AUTOFD])
    begin
      n.svalid = 1'b1; // RULE20
      n.sdata = r.s2[17:10]; // RULE8
      n.ssync = p[`PAP_P_BUSY]; // RULE2
      n.stag = {p[`PAP_P_INIT], p[`PAP_P_SEL], p[`PAP_P_PERR]}; // RULE7
      n.sadp = p[`PAP_P_SELIN]; // RULE14
      n.snm = p[`PAP_P_ACK]; // RULE21
    end
    if (sys_rst)
    begin
      n = '0;
      n.st = PAP_H_IDLE;
      n.stb_n = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    r <= n;
  end

  // init and select-in are active low levels
  assign vec = {strap_value, 1'b1, r.hval, src_on ? r.herr : !sel_req, 2'b11,
                !init_req, r.hclk, r.hsync, aux_mode ? aux_dev_out : r.stb_n}; // RULE6 RULE13 RULE17
  assign link.host_o = vec;
  // board strap held while in reset
  assign link.host_oe = sys_rst ? 10'h200 :
                        !aux_mode ? `PAP_HOE_1284 : src_on ? `PAP_HOE_ASRC : `PAP_HOE_ASNK; // RULE10
  assign link.host_d = r.d;
  assign link.host_doe = !sys_rst && (src_on || (!aux_mode && r.st != PAP_H_IDLE && r.st != PAP_H_DONE));
  assign send_ready = !aux_mode && !init_req && r.st == PAP_H_IDLE && !p[`PAP_P_BUSY];
  assign dev_busy = p[`PAP_P_BUSY];
  assign dev_fault = !p[`PAP_P_FAULT];
  assign dev_perror = p[`PAP_P_PERR];
  assign dev_select = p[`PAP_P_SEL];
  assign src_ready = fall && !sys_rst;
  assign snk_valid = r.svalid;
  assign snk_data = r.sdata;
  assign snk_sync = r.ssync;
  assign snk_tag = r.stag;
  assign snk_adp = r.sadp;
  assign snk_nm = r.snm;
endmodule

// File: test/dual_mode_parallel_aux_port_bench.sv
// bench joining device and host ends over the link interface
// assumes AHB-Lite zero-wait slave and host sender/source/sink ports
`timescale 1ns/1ps
`include "pap_defines.svh"
module dual_mode_parallel_aux_port_bench;
  import pap_pkg::*;
  logic core_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, proc_error = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0, tx_tag = 0, snk_tag;
  logic tx_valid = 0, tx_sync = 0, tx_adapt = 0, tx_nomatch = 0, tx_ready, rx_valid, rx_sync, rx_err;
  logic [7:0] tx_data = 0, rx_data, send_data = 0, src_data = 0, snk_data;
  logic aux_mode = 0, aux_dev_out = 0, init_req = 0, sel_req = 0, send_valid = 0, send_ready;
  logic dev_busy, dev_fault, dev_perror, dev_select, src_valid = 0, src_sync = 0, src_err = 0;
  logic src_ready, snk_valid, snk_sync, snk_adp, snk_nm;
  logic [13:0] got_q[$], exp_q[$], e; // {sync, tag, adapt/err, nomatch, byte}
  int failures = 0, tests_run = 0, n, i;
  pap_link_if link();
  pap_device u_pap_device(.core_clk, .sys_rst, .link, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .proc_error, .tx_valid, .tx_data, .tx_sync, .tx_tag,
    .tx_adapt, .tx_nomatch, .tx_ready, .rx_valid, .rx_data, .rx_sync, .rx_err);
  pap_host #(.HALF(4)) u_pap_host(.core_clk, .sys_rst, .link, .aux_mode, .aux_dev_out, .strap_value(1'b0),
    .init_req, .sel_req, .send_valid, .send_data, .send_ready, .dev_busy, .dev_fault, .dev_perror, .dev_select,
    .src_valid, .src_data, .src_sync, .src_err, .src_ready, .snk_valid, .snk_data, .snk_sync, .snk_tag,
    .snk_adp, .snk_nm);
  pap_checker u_pap_checker(.core_clk, .sys_rst, .pin(link.pin), .dev_o(link.dev_o), .dev_oe(link.dev_oe),
    .data(link.data));
  // 25 MHz core clock
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  // bytes seen at either stream sink; 1284 bytes are checked inline
  always @(posedge core_clk)
  begin
    if (snk_valid === 1'b1)
      got_q.push_back({snk_sync, snk_tag, snk_adp, snk_nm, snk_data});
    if (rx_valid === 1'b1 && aux_mode && !aux_dev_out)
      got_q.push_back({rx_sync, 3'h0, rx_err, 1'b0, rx_data});
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single-word AHB transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    {hsel, haddr, htrans, hwrite, hsize} <= {1'b1, 24'h0, a, 2'b10, wr, 3'b010};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // poll a status bit until it reaches v, then compare
  task automatic poll(input int b, input logic v);
    for (n = 0; n < 30; n++)
    begin
      bus(0, `PAP_A_ST, 0);
      if (rd[b] === v)
        break;
    end
    check(rd[b], v);
  endtask
  // compare collected stream bytes against what was sent
  task automatic cmp_q;
    for (n = 0; n < 600 && got_q.size() < exp_q.size(); n++)
      @(posedge core_clk);
    check(got_q.size(), exp_q.size());
    foreach (exp_q[k])
      if (k < got_q.size())
        check(got_q[k], exp_q[k]);
    got_q = {};
    exp_q = {};
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, well past the expected run length
  initial
  begin
    repeat (40000) @(posedge core_clk);
    failures++;
    $display("watchdog expired");
    test_done;
  end
  initial
  begin
    void'($urandom(32'hadbb));
    repeat (4) @(posedge core_clk);
    sys_rst <= 0;
    bus(0, `PAP_A_ST, 0);
    check(rd, 32'h0);
    check({hresp, hreadyout}, 2'b01);
    check({link.pin[9:8], link.pin[2:1]}, 4'b0110);
    bus(0, 8'h10, 0);
    check(rd, 32'h0);
    $display("test reset done");
    sel_req <= 1;
    poll(5, 1);
    check(link.pin[`PAP_P_SEL], 1);
    for (i = 0; i < 8; i++)
    begin
      e[7:0] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      {send_valid, send_data} <= {1'b1, e[7:0]};
      do @(posedge core_clk); while (send_ready !== 1'b1);
      send_valid <= 0;
      for (n = 0; n < 300 && rx_valid !== 1'b1; n++) @(posedge core_clk);
      check({link.pin[`PAP_P_ACK], link.pin[`PAP_P_BUSY], rx_sync, rx_err, rx_data}, {4'b0100, e[7:0]});
    end
    poll(0, 0);
    $display("test strobe bytes done");
    proc_error <= 1;
    @(posedge core_clk);
    proc_error <= 0;
    poll(1, 1);
    check({link.pin[`PAP_P_PERR], link.pin[`PAP_P_FAULT]}, 2'b10);
    check({dev_perror, dev_fault, dev_select}, 3'b111);
    bus(1, `PAP_A_ST, 32'h2);
    poll(1, 0);
    check({link.pin[`PAP_P_PERR], link.pin[`PAP_P_FAULT]}, 2'b01);
    check({dev_perror, dev_fault}, 2'b00);
    $display("test fault done");
    init_req <= 1;
    poll(5, 0);
    init_req <= 0;
    check(link.pin[`PAP_P_SEL], 0);
    $display("test init done");
    bus(1, `PAP_A_GP, 32'h8);
    // the write landed at the last edge of bus; this edge lets the new drive mask settle
    @(posedge core_clk);
    check(link.dev_oe, 10'h0);
    bus(1, `PAP_A_GP, 32'h0);
    @(posedge core_clk);
    check(link.dev_oe, `PAP_DOE_1284);
    $display("test gpio done");
    bus(1, `PAP_A_AC, 32'h5);
    bus(1, `PAP_A_SYS, 32'h10);
    {aux_mode, aux_dev_out} <= 2'b11;
    fork
      for (i = 0; i < 10; i++)
      begin
        e = {i % 5 == 0, 13'($urandom)};
        exp_q.push_back(e);
        {tx_valid, tx_sync, tx_tag, tx_adapt, tx_nomatch, tx_data} <= {1'b1, e};
        do @(posedge core_clk); while (tx_ready !== 1'b1);
      end
      begin
        for (n = 0; n < 99 && link.pin[2] !== 1'b0; n++) @(posedge core_clk);
        for (n = 0; n < 99 && link.pin[2] !== 1'b1; n++) @(posedge core_clk);
        for (n = 0; n < 99 && link.pin[2] !== 1'b0; n++) @(posedge core_clk);
        for (; n < 99 && link.pin[2] !== 1'b1; n++) @(posedge core_clk);
        check(n == `PAP_CORE_HZ / `PAP_F2_HZ || n == `PAP_CORE_HZ / `PAP_F2_HZ + 1, 1);
      end
    join
    tx_valid <= 0;
    cmp_q;
    check(link.pin[`PAP_P_DIR], 1);
    $display("test aux output done");
    bus(1, `PAP_A_AC, 32'h0);
    aux_dev_out <= 0;
    for (i = 0; i < 10; i++)
    begin
      e = {i % 5 == 0, 3'h0, 1'($urandom), 1'b0, 8'($urandom)};
      exp_q.push_back(e);
      {src_valid, src_sync, src_err, src_data} <= {1'b1, e[13], e[9], e[7:0]};
      do @(posedge core_clk); while (src_ready !== 1'b1);
    end
    src_valid <= 0;
    cmp_q;
    $display("test aux input done");
    bus(1, `PAP_A_AC, 32'h10);
    aux_dev_out <= 1;
    poll(4, 1);
    aux_dev_out <= 0;
    poll(4, 0);
    $display("test pin direction done");
    test_done;
  end
endmodule

// File: test/pap_checker.sv
// pin-level checks of the device end of the parallel / aux link
// assumes the link interface signals, one clock, sync active-high reset
`timescale 1ns/1ps
`include "pap_defines.svh"
module pap_checker
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [9:0] pin,
  input wire logic [9:0] dev_o,
  input wire logic [9:0] dev_oe,
  input wire logic [7:0] data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] ack_cnt; // cycles the acknowledge has been low
  logic m1284; // device drives the 1284 pin set
  logic maout; // device drives the aux output pin set
  assign m1284 = dev_oe == `PAP_DOE_1284;
  assign maout = dev_oe == `PAP_DOE_AOUT;
  // saturating count, so a stuck acknowledge cannot wrap to 13
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || dev_o[`PAP_P_ACK])
      ack_cnt <= 8'h00;
    else if (ack_cnt != 8'hff)
      ack_cnt <= ack_cnt + 8'h01;
  end
  property p_oe_modes;
    dev_oe inside {10'h000, `PAP_DOE_1284, `PAP_DOE_AOUT, `PAP_DOE_AIN};
  endproperty
  a_oe_modes: assert property (p_oe_modes) else $error("device drive mask fits no mode");
  property p_dir_aux;
    (maout || dev_oe == `PAP_DOE_AIN) |-> dev_o[`PAP_P_DIR];
  endproperty
  a_dir_aux: assert property (p_dir_aux) else $error("direction pin low in aux mode");
  property p_dir_1284;
    m1284 |-> !dev_o[`PAP_P_DIR];
  endproperty
  a_dir_1284: assert property (p_dir_1284) else $error("direction pin high in 1284 mode");
  property p_fault_perr;
    m1284 && dev_o[`PAP_P_PERR] && $past(dev_o[`PAP_P_PERR]) |-> !dev_o[`PAP_P_FAULT];
  endproperty
  a_fault_perr: assert property (p_fault_perr) else $error("paper error without fault");
  property p_busy_strobe;
    m1284 && $rose(pin[`PAP_P_STB]) && !pin[`PAP_P_BUSY] && pin[`PAP_P_INIT] |-> ##[1:4] pin[`PAP_P_BUSY];
  endproperty
  a_busy_strobe: assert property (p_busy_strobe) else $error("no busy after strobe");
  property p_ack_width;
    m1284 && $past(m1284) && pin[`PAP_P_INIT] && $rose(dev_o[`PAP_P_ACK]) |-> ack_cnt == 8'(`PAP_ACK_CYC);
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("acknowledge width wrong");
  property p_busy_ack;
    m1284 && !dev_o[`PAP_P_ACK] |-> dev_o[`PAP_P_BUSY];
  endproperty
  a_busy_ack: assert property (p_busy_ack) else $error("busy released before acknowledge ends");
  property p_aux_stable;
    maout && $past(maout) && $rose(dev_o[`PAP_P_FAULT]) |-> $stable(data) && $stable(dev_o[8:3]);
  endproperty
  a_aux_stable: assert property (p_aux_stable) else $error("aux byte moved at clock rise");
endmodule
